// file: pkg/mpu_consts.svh
`ifndef MPU_CONSTS_SVH
`define MPU_CONSTS_SVH

// register byte offsets
`define MPU_OFS_CAP_CH2      12'h104
`define MPU_OFS_CAP_STATUS   12'h108
`define MPU_OFS_UPD_CTRL     12'h10c
`define MPU_OFS_IRQ_ENA      12'h110
`define MPU_OFS_IRQ_RAW      12'h114
`define MPU_OFS_IRQ_MASKED   12'h118
`define MPU_OFS_IRQ_CLR      12'h11c

// shadow_update_control field positions
`define MPU_UPD_GLOBAL_EN    0
`define MPU_UPD_GLOBAL_FORCE 1
`define MPU_UPD_OP0_EN       2
`define MPU_UPD_OP0_FORCE    3
`define MPU_UPD_OP1_EN       4
`define MPU_UPD_OP1_FORCE    5
`define MPU_UPD_OP2_EN       6
`define MPU_UPD_OP2_FORCE    7
`define MPU_UPD_WIDTH        8

// reset values
`define MPU_RST_CAP_CH2      32'h0000_0000
`define MPU_RST_CAP_STATUS   3'h0
`define MPU_RST_UPD_CTRL     8'h00
`define MPU_RST_IRQ_ENA      30'h0000_0000
`define MPU_RST_IRQ_RAW      30'h0000_0000

// interrupt sources and bus answers
`define MPU_IRQ_COUNT        30
`define MPU_RESP_OKAY        2'h0
`define MPU_RESP_DECODEERR   2'h3

`endif

// file: pkg/mpu_pkg.sv
package mpu_pkg;

  // interrupt vector, first field at bit 29, last at bit 0
  typedef struct packed {
    logic [2:0] capture;
    logic [2:0] one_shot_trip;
    logic [2:0] per_cycle_trip;
    logic [2:0] comparator_b_match_event;
    logic [2:0] comparator_a_match_event;
    logic [2:0] fault_end;
    logic [2:0] fault_start;
    logic [2:0] timer_period_event;
    logic [2:0] timer_zero_event;
    logic [2:0] timer_stop;
  } mpu_irq_vec_t;

  // event sources from the pwm datapath; pulses except the two levels
  typedef struct packed {
    logic [2:0] capture;
    logic [2:0] one_shot_trip;
    logic [2:0] per_cycle_trip;
    logic [2:0] comparator_b_match_event;
    logic [2:0] comparator_a_match_event;
    logic [2:0] fault_level;
    logic [2:0] timer_period_event;
    logic [2:0] timer_zero_event;
    logic [2:0] timer_running;
  } mpu_src_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [11:0] address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } mpu_av_req_t;

  typedef enum logic {
    MPU_BUS_IDLE,
    MPU_BUS_ACK
  } mpu_bus_state_t;

endpackage

// file: hw/mpu_irq_bank.sv
`timescale 1ns/1ps
module mpu_irq_bank #(
  parameter int N = 30
) (
  // clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rst_b_i,
  // sources and software control
  input  wire logic [N-1:0] event_i,
  input  wire logic [N-1:0] enable_i,
  input  wire logic [N-1:0] clear_i,
  // status
  output logic      [N-1:0] raw_o,
  output logic              irq_o
);

  logic [N-1:0] raw_reg;
  logic [N-1:0] raw_next;
  logic         irq_reg;
  logic         irq_next;

  // an event in the clearing cycle survives the clear
  assign raw_next = event_i | (raw_reg & ~clear_i);
  assign irq_next = |(raw_next & enable_i);

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      raw_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      raw_reg <= raw_next;
      irq_reg <= irq_next;
    end
  end

  assign raw_o = raw_reg;
  assign irq_o = irq_reg;

endmodule

// file: hw/mpu_pwm_upd_irq.sv
// Function
// - read-only register holds timer value of the latest channel 2 capture, resets zero
// - inverting an operator force-update bit forces that operator's shadow load
// - inverting the global force-update bit forces a load of every active register
// - automatic shadow transfers happen only while global update enable is set
// - automatic operator loads need both the operator enable and the global enable
// - thirty read-write interrupt enable bits, all zero after reset
// - raw status records each event regardless of enable, resets zero
// - masked status is raw and enable; interrupt line is driven from it
// - each capture channel 0 to 2 has its own interrupt source
// - one-shot trip on each output 0 to 2 has its own source
// - cycle-by-cycle trip on each output 0 to 2 has its own source
// - comparator B match of each operator has its own source
// - comparator A match of each operator has its own source
// - end of each fault input has its own source
// - start of each fault input has its own source
// - period event of each timer has its own source
// - zero event of each timer has its own source
// - stop of each timer has its own source
// - writing one to a clear bit resets the matching raw bit
`timescale 1ns/1ps
`include "mpu_consts.svh"
module mpu_pwm_upd_irq #(
  parameter int NUM_OPS = 3,
  parameter int CAP_W   = 32
) (
  // clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 rst_b_i,
  // avalon-mm slave
  input  wire mpu_pkg::mpu_av_req_t av_req_i,
  output logic                      waitrequest_o,
  output logic [31:0]               readdata_o,
  output logic [1:0]                response_o,
  // capture datapath
  input  wire logic [CAP_W-1:0]     capture_value_i,
  input  wire logic [2:0]           capture_edge_i,
  // event sources
  input  wire mpu_pkg::mpu_src_t    src_i,
  // shadow load control
  input  wire logic [NUM_OPS-1:0]   op_load_point_i,
  input  wire logic                 global_load_point_i,
  output logic [NUM_OPS-1:0]        op_load_o,
  output logic                      global_load_o,
  output logic [NUM_OPS-1:0]        op_load_allow_o,
  output logic                      global_load_allow_o,
  // interrupt
  output logic                      irq_o
);

  localparam int NI = `MPU_IRQ_COUNT;

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // bus handshake
  mpu_pkg::mpu_bus_state_t state_reg;
  mpu_pkg::mpu_bus_state_t state_next;
  logic                    waitrequest_reg;
  logic [31:0]             readdata_reg;
  logic [31:0]             readdata_next;
  logic [1:0]              response_reg;
  logic [1:0]              response_next;

  wire        req_any  = av_req_i.read | av_req_i.write;
  wire        wr_fire  = (state_reg == mpu_pkg::MPU_BUS_ACK) & av_req_i.write;
  wire [11:0] word_adr = {av_req_i.address[11:2], 2'b00};

  wire sel_cap   = (word_adr == `MPU_OFS_CAP_CH2);
  wire sel_stat  = (word_adr == `MPU_OFS_CAP_STATUS);
  wire sel_upd   = (word_adr == `MPU_OFS_UPD_CTRL);
  wire sel_ena   = (word_adr == `MPU_OFS_IRQ_ENA);
  wire sel_raw   = (word_adr == `MPU_OFS_IRQ_RAW);
  wire sel_mask  = (word_adr == `MPU_OFS_IRQ_MASKED);
  wire sel_clr   = (word_adr == `MPU_OFS_IRQ_CLR);
  wire sel_any   = sel_cap | sel_stat | sel_upd | sel_ena | sel_raw | sel_mask | sel_clr;

  // request is answered one edge after it is seen; the master samples the
  // answer on the following edge, which is also the edge a write lands on
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      mpu_pkg::MPU_BUS_IDLE: begin
        if (req_any) begin
          state_next = mpu_pkg::MPU_BUS_ACK;
        end
      end
      mpu_pkg::MPU_BUS_ACK: begin
        state_next = mpu_pkg::MPU_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg       <= mpu_pkg::MPU_BUS_IDLE;
      waitrequest_reg <= 1'b1;
    end else begin
      state_reg       <= state_next;
      waitrequest_reg <= (state_next != mpu_pkg::MPU_BUS_ACK);
    end
  end

  // capture registers
  logic [CAP_W-1:0] cap_ch2_reg;
  logic [2:0]       cap_stat_reg;
  logic [2:0]       cap_stat_next;

  always_comb begin
    for (int c = 0; c < 3; c++) begin
      cap_stat_next[c] = src_i.capture[c] ? capture_edge_i[c] : cap_stat_reg[c];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cap_ch2_reg  <= CAP_W'(`MPU_RST_CAP_CH2);
      cap_stat_reg <= `MPU_RST_CAP_STATUS;
    end else begin
      if (src_i.capture[2]) begin
        cap_ch2_reg <= capture_value_i;
      end
      cap_stat_reg <= cap_stat_next;
    end
  end

  // shadow update control
  logic [`MPU_UPD_WIDTH-1:0] upd_reg;
  logic [`MPU_UPD_WIDTH-1:0] upd_next;
  logic [NUM_OPS-1:0]        op_load_reg;
  logic [NUM_OPS-1:0]        op_load_next;
  logic [NUM_OPS-1:0]        op_allow_reg;
  logic                      glb_load_reg;
  logic                      glb_allow_reg;

  wire [31:0] upd_merged = be_merge({{(32-`MPU_UPD_WIDTH){1'b0}}, upd_reg},
                                    av_req_i.writedata, av_req_i.byteenable);
  wire        upd_wr     = wr_fire & sel_upd;
  assign upd_next = upd_wr ? upd_merged[`MPU_UPD_WIDTH-1:0] : upd_reg;

  // a force request is any change of the toggle bit, not its level
  wire [`MPU_UPD_WIDTH-1:0] upd_flip = upd_next ^ upd_reg;
  wire                      glb_en    = upd_reg[`MPU_UPD_GLOBAL_EN];
  wire                      glb_force = upd_flip[`MPU_UPD_GLOBAL_FORCE];

  wire [2:0] op_en    = {upd_reg[`MPU_UPD_OP2_EN],
                         upd_reg[`MPU_UPD_OP1_EN],
                         upd_reg[`MPU_UPD_OP0_EN]};
  wire [2:0] op_force = {upd_flip[`MPU_UPD_OP2_FORCE],
                         upd_flip[`MPU_UPD_OP1_FORCE],
                         upd_flip[`MPU_UPD_OP0_FORCE]};

  wire [NUM_OPS-1:0] op_allow = op_en[NUM_OPS-1:0] & {NUM_OPS{glb_en}};

  // forced loads bypass the enables; automatic loads need the enables
  assign op_load_next = op_force[NUM_OPS-1:0]
                      | {NUM_OPS{glb_force}}
                      | (op_load_point_i & op_allow);

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      upd_reg       <= `MPU_RST_UPD_CTRL;
      op_load_reg   <= '0;
      op_allow_reg  <= '0;
      glb_load_reg  <= 1'b0;
      glb_allow_reg <= 1'b0;
    end else begin
      upd_reg       <= upd_next;
      op_load_reg   <= op_load_next;
      op_allow_reg  <= op_allow;
      glb_load_reg  <= glb_force | (global_load_point_i & glb_en);
      glb_allow_reg <= glb_en;
    end
  end

  // interrupt sources
  logic [2:0] fault_prev_reg;
  logic [2:0] run_prev_reg;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fault_prev_reg <= 3'h0;
      run_prev_reg   <= 3'h0;
    end else begin
      fault_prev_reg <= src_i.fault_level;
      run_prev_reg   <= src_i.timer_running;
    end
  end

  mpu_pkg::mpu_irq_vec_t evt;

  assign evt.capture                  = src_i.capture;
  assign evt.one_shot_trip            = src_i.one_shot_trip;
  assign evt.per_cycle_trip           = src_i.per_cycle_trip;
  assign evt.comparator_b_match_event = src_i.comparator_b_match_event;
  assign evt.comparator_a_match_event = src_i.comparator_a_match_event;
  assign evt.fault_end                = fault_prev_reg & ~src_i.fault_level;
  assign evt.fault_start              = ~fault_prev_reg & src_i.fault_level;
  assign evt.timer_period_event       = src_i.timer_period_event;
  assign evt.timer_zero_event         = src_i.timer_zero_event;
  assign evt.timer_stop               = run_prev_reg & ~src_i.timer_running;

  // interrupt registers
  logic [NI-1:0] ena_reg;
  logic [NI-1:0] raw_w;

  wire [31:0] ena_merged = be_merge({2'b00, ena_reg}, av_req_i.writedata, av_req_i.byteenable);
  wire [31:0] clr_merged = be_merge(32'h0000_0000, av_req_i.writedata, av_req_i.byteenable);
  wire [NI-1:0] clr_vec  = (wr_fire & sel_clr) ? clr_merged[NI-1:0] : '0;
  wire [NI-1:0] masked   = raw_w & ena_reg;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ena_reg <= `MPU_RST_IRQ_ENA;
    end else if (wr_fire & sel_ena) begin
      ena_reg <= ena_merged[NI-1:0];
    end
  end

  mpu_irq_bank #(
    .N (NI)
  ) u_irq_bank (
    .mclk_i   (mclk_i),
    .rst_b_i  (rst_b_i),
    .event_i  (evt),
    .enable_i (ena_reg),
    .clear_i  (clr_vec),
    .raw_o    (raw_w),
    .irq_o    (irq_o)
  );

  // read mux
  // clear register is write-only and reads zero; unused high bits read zero
  wire [31:0] rd_cap  = 32'(cap_ch2_reg);
  wire [31:0] rd_stat = {29'h0000_0000, cap_stat_reg};
  wire [31:0] rd_upd  = {{(32-`MPU_UPD_WIDTH){1'b0}}, upd_reg};
  wire [31:0] rd_ena  = {2'b00, ena_reg};
  wire [31:0] rd_raw  = {2'b00, raw_w};
  wire [31:0] rd_mask = {2'b00, masked};

  assign readdata_next = ({32{sel_cap}}  & rd_cap)
                       | ({32{sel_stat}} & rd_stat)
                       | ({32{sel_upd}}  & rd_upd)
                       | ({32{sel_ena}}  & rd_ena)
                       | ({32{sel_raw}}  & rd_raw)
                       | ({32{sel_mask}} & rd_mask);
  assign response_next = sel_any ? `MPU_RESP_OKAY : `MPU_RESP_DECODEERR;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      readdata_reg <= 32'h0000_0000;
      response_reg <= `MPU_RESP_OKAY;
    end else if (state_reg == mpu_pkg::MPU_BUS_IDLE && req_any) begin
      readdata_reg <= av_req_i.read ? readdata_next : 32'h0000_0000;
      response_reg <= response_next;
    end
  end

  assign waitrequest_o       = waitrequest_reg;
  assign readdata_o          = readdata_reg;
  assign response_o          = response_reg;
  assign op_load_o           = op_load_reg;
  assign global_load_o       = glb_load_reg;
  assign op_load_allow_o     = op_allow_reg;
  assign global_load_allow_o = glb_allow_reg;

endmodule

// file: verif/mpu_pwm_upd_irq_props.sv
`timescale 1ns/1ps
module mpu_pwm_upd_irq_props #(
  parameter int NUM_OPS = 3,
  parameter int CAP_W   = 32
) (
  // clock, reset and bus
  input wire logic                 mclk_i,
  input wire logic                 rst_b_i,
  input wire mpu_pkg::mpu_av_req_t av_req_i,
  input wire logic                 waitrequest_o,
  input wire logic [31:0]          readdata_o,
  input wire logic [1:0]           response_o,
  // datapath side
  input wire logic [CAP_W-1:0]     capture_value_i,
  input wire logic [2:0]           capture_edge_i,
  input wire mpu_pkg::mpu_src_t    src_i,
  input wire logic [NUM_OPS-1:0]   op_load_point_i,
  input wire logic                 global_load_point_i,
  input wire logic [NUM_OPS-1:0]   op_load_o,
  input wire logic                 global_load_o,
  input wire logic [NUM_OPS-1:0]   op_load_allow_o,
  input wire logic                 global_load_allow_o,
  input wire logic                 irq_o
);
  logic [CAP_W-1:0] cap_exp;
  logic [29:0]      ena_exp;
  logic [7:0]       upd_exp;
  wire              rd_ack = !waitrequest_o && av_req_i.read;
  wire              wr_ack = !waitrequest_o && av_req_i.write;
  wire [11:0]       wa     = {av_req_i.address[11:2], 2'b00};
  wire [7:0]        wd     = av_req_i.writedata[7:0];
  wire              wr_upd = wr_ack && wa == 12'h10c && av_req_i.byteenable[0];
  wire [3:0]        be     = av_req_i.byteenable;
  wire [31:0]       bm     = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  wire              gflip  = wr_upd && (wd[1] != upd_exp[1]);
  wire [2:0]        oflip  = {3{wr_upd}} & ({wd[7], wd[5], wd[3]} ^ {upd_exp[7], upd_exp[5], upd_exp[3]});

  // shadow copies of the channel 2 capture and of what software wrote, so reads and loads can be judged
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cap_exp <= '0;
      ena_exp <= '0;
      upd_exp <= '0;
    end else begin
      if (src_i.capture[2]) cap_exp <= capture_value_i;
      if (wr_ack && wa == 12'h110) ena_exp <= (ena_exp & ~bm[29:0]) | (av_req_i.writedata[29:0] & bm[29:0]);
      if (wr_upd) upd_exp <= wd;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  property p_force(int k);
    oflip[k] |-> ##[1:2] op_load_o[k];
  endproperty

  AST_CAP_VALUE: assert property (rd_ack && wa == 12'h104 |-> readdata_o == $past(cap_exp))
    else $error("capture value read mismatch");
  AST_ENA_VALUE: assert property (rd_ack && wa == 12'h110 |-> readdata_o == {2'b00, $past(ena_exp)})
    else $error("enable read mismatch");
  AST_TOP_ZERO: assert property (rd_ack && (wa == 12'h114 || wa == 12'h118) |-> readdata_o[31:30] == 2'b00)
    else $error("status bits above 29 set");
  AST_IRQ_OFF: assert property ((ena_exp == 30'h0)[*3] |-> !irq_o)
    else $error("interrupt with all sources disabled");
  AST_OP_ALLOW: assert property (op_load_allow_o == ($past({upd_exp[6], upd_exp[4], upd_exp[2]}) & {3{$past(upd_exp[0])}}))
    else $error("operator allow mismatch");
  AST_GLB_ALLOW: assert property (global_load_allow_o == $past(upd_exp[0]))
    else $error("global allow mismatch");
  AST_GLB_FORCE: assert property (gflip |-> ##[1:2] (global_load_o && op_load_o == 3'h7))
    else $error("global force load missing");
  AST_OP0_FORCE: assert property (p_force(0))
    else $error("operator 0 force load missing");
  AST_OP2_FORCE: assert property (p_force(2))
    else $error("operator 2 force load missing");
  AST_AUTO_LOAD: assert property ((upd_exp[0] && upd_exp[4])[*3] ##0 op_load_point_i[1] |-> ##[1:2] op_load_o[1])
    else $error("operator 1 automatic load missing");
  AST_NO_LOAD: assert property ((!upd_exp[0] && !wr_upd)[*4] |-> (op_load_o == 3'h0 && !global_load_o))
    else $error("load while global enable clear");

  cover property (gflip);
  cover property (irq_o);
  cover property (op_load_point_i[1] && op_load_allow_o[1]);
endmodule

bind mpu_pwm_upd_irq mpu_pwm_upd_irq_props #(.NUM_OPS(NUM_OPS), .CAP_W(CAP_W)) u_props (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .av_req_i(av_req_i), .waitrequest_o(waitrequest_o),
  .readdata_o(readdata_o), .response_o(response_o), .capture_value_i(capture_value_i),
  .capture_edge_i(capture_edge_i), .src_i(src_i), .op_load_point_i(op_load_point_i),
  .global_load_point_i(global_load_point_i), .op_load_o(op_load_o), .global_load_o(global_load_o),
  .op_load_allow_o(op_load_allow_o), .global_load_allow_o(global_load_allow_o), .irq_o(irq_o));

// file: verif/mpu_pwm_upd_irq_bench.sv
`timescale 1ns/1ps
module mpu_pwm_upd_irq_bench;
  logic                 mclk_i   = 1'b0;
  logic                 rst_b_i  = 1'b0;
  mpu_pkg::mpu_av_req_t req      = '0;
  mpu_pkg::mpu_src_t    src;
  logic [31:0]          cap_val  = 32'hc3a5_0f1e;
  logic [2:0]           op_pt    = 3'h0;
  logic                 gl_pt    = 1'b0;
  logic                 waitreq, irq, gl_ld, gl_al;
  logic [31:0]          rdata, rd;
  logic [1:0]           resp, rs;
  logic [2:0]           op_ld, op_al;
  logic [7:0]           u;
  int                   cnt [4]  = '{default: 0};
  int                   base [4];
  int                   err_total = 0;
  int                   n_tests   = 0;

  always #2 mclk_i = ~mclk_i;

  mpu_pwm_upd_irq uut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .av_req_i(req), .waitrequest_o(waitreq), .readdata_o(rdata),
    .response_o(resp), .capture_value_i(cap_val), .capture_edge_i(3'h5), .src_i(src),
    .op_load_point_i(op_pt), .global_load_point_i(gl_pt), .op_load_o(op_ld), .global_load_o(gl_ld),
    .op_load_allow_o(op_al), .global_load_allow_o(gl_al), .irq_o(irq));

  // pulses are counted, not sampled, so one test never misses a pulse of uncertain phase
  always @(posedge mclk_i) begin
    for (int b = 0; b < 3; b++) cnt[b] <= cnt[b] + op_ld[b];
    cnt[3] <= cnt[3] + gl_ld;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // no local limit: only the watchdog may end a wait for the answer
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    req.read <= ~wr;
    req.write <= wr;
    req.address <= a;
    req.writedata <= wd;
    req.byteenable <= 4'hf;
    do begin
      @(posedge mclk_i);
    end while (waitreq !== 1'b0);
    rd = rdata;
    rs = resp;
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic rdchk(input logic [11:0] a, input string nm, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  task automatic pt(input logic [2:0] o, input logic g);
    base = cnt;
    op_pt <= o;
    gl_pt <= g;
    @(posedge mclk_i);
    op_pt <= 3'h0;
    gl_pt <= 1'b0;
    repeat (4) @(posedge mclk_i);
  endtask

  function automatic logic [15:0] dl();
    logic [15:0] r;
    for (int b = 0; b < 4; b++) r[4*b +: 4] = 4'(cnt[b] - base[b]);
    return r;
  endfunction

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk_i);
    err_total++;
    summarize();
  end

  initial begin
    int pos;
    src <= 27'h000_0007;
    repeat (16) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    rdchk(12'h104, "cap2_rst", 32'h0);
    rdchk(12'h110, "ena_rst", 32'h0);
    rdchk(12'h114, "raw_rst", 32'h0);
    $display("test reset done");
    bus(1'b1, 12'h110, 32'hffff_ffff);
    rdchk(12'h110, "ena_rw", 32'h3fff_ffff);
    bus(1'b1, 12'h110, 32'h0);
    bus(1'b1, 12'h114, 32'hffff_ffff);
    rdchk(12'h114, "raw_ro", 32'h0);
    bus(1'b0, 12'h120, 32'h0);
    chk("unmapped_resp", {30'h0, rs}, 32'h3);
    chk("unmapped_data", rd, 32'h0);
    $display("test registers done");
    // levels flip once per event, pulses rise for one cycle only
    for (int i = 0; i < 30; i++) begin
      pos = (i >= 12) ? i - 3 : i;
      src[pos] <= ~src[pos];
      @(posedge mclk_i);
      if (!(pos < 3 || (pos >= 9 && pos < 12))) src[pos] <= ~src[pos];
      repeat (3) @(posedge mclk_i);
      rdchk(12'h114, "raw_set", 32'h1 << i);
      rdchk(12'h118, "masked_off", 32'h0);
      chk("irq_off", {31'h0, irq}, 32'h0);
      bus(1'b1, 12'h110, 32'h1 << i);
      repeat (2) @(posedge mclk_i);
      chk("irq_on", {31'h0, irq}, 32'h1);
      rdchk(12'h118, "masked_on", 32'h1 << i);
      bus(1'b1, 12'h11c, 32'h1 << i);
      repeat (2) @(posedge mclk_i);
      rdchk(12'h114, "raw_clr", 32'h0);
      chk("irq_clr", {31'h0, irq}, 32'h0);
      bus(1'b1, 12'h110, 32'h0);
    end
    rdchk(12'h104, "cap2_value", cap_val);
    rdchk(12'h108, "cap_status", 32'h5);
    $display("test sources done");
    bus(1'b1, 12'h10c, 32'h55);
    repeat (2) @(posedge mclk_i);
    chk("op_allow", {29'h0, op_al}, 32'h7);
    chk("glb_allow", {31'h0, gl_al}, 32'h1);
    pt(3'h2, 1'b0);
    chk("auto_op1", {16'h0, dl()}, 32'h0010);
    pt(3'h0, 1'b1);
    chk("auto_glb", {16'h0, dl()}, 32'h1000);
    // operators 0 and 2 enabled, operator 1 held off
    bus(1'b1, 12'h10c, 32'h45);
    repeat (2) @(posedge mclk_i);
    chk("op_allow_part", {29'h0, op_al}, 32'h5);
    pt(3'h7, 1'b0);
    chk("auto_part", {16'h0, dl()}, 32'h0101);
    bus(1'b1, 12'h10c, 32'h50);
    pt(3'h7, 1'b1);
    chk("auto_off", {16'h0, dl()}, 32'h0);
    chk("op_allow_off", {29'h0, op_al}, 32'h0);
    u = 8'h50;
    for (int k = 0; k < 4; k++) begin
      u ^= 8'h8 << (2 * (k % 3));
      base = cnt;
      bus(1'b1, 12'h10c, {24'h0, u});
      repeat (3) @(posedge mclk_i);
      chk("force_op", {16'h0, dl()}, 32'h1 << (4 * (k % 3)));
    end
    u ^= 8'h2;
    base = cnt;
    bus(1'b1, 12'h10c, {24'h0, u});
    repeat (3) @(posedge mclk_i);
    chk("force_glb", {16'h0, dl()}, 32'h1111);
    $display("test loads done");
    summarize();
  end
endmodule
